// File: cdma_defs.vh
`ifndef CDMA_DEFS_VH
`define CDMA_DEFS_VH
// Behaviour
// - Dual-buffer mode places the next descriptor after a programmed skip length.
// - Chained mode: one buffer per descriptor plus next descriptor address.
// - Descriptor is four aligned 32-bit words, sixteen bytes.
// - Ownership bit 31 set means engine owns; engine clears it when done.
// - Bit 30 written back as OR of the card error flags.
// - Ring wrap bit returns to list base, dual-buffer mode only.
// - Link bit makes word 3 the next descriptor address; size two zero.
// - First flag marks data start; empty first buffer defers start onward. The engine never reads this bit.
// - Final flag marks the descriptor holding the last buffers.
// - Suppress bit blocks done flag for data ending in this descriptor.
// - Zero first size skips to next buffer or next descriptor.
// - Word 2 is buffer one address; low two bits ignored.
// - Word 3 is buffer two or link address; low two bits ignored.
// - Fixed bursts on select, limited by burst length; fetches as INCR4.
// - Data burst starts only with FIFO room or short remainder.
// - Fixed: INCR4/8/16 and SINGLE mix; else INCR and SINGLE.
// - Writes to card move exactly the programmed byte count; the engine moves whole words, the low two size bits dropped.
// - Non-final buffers full; final buffer may end early on receive.
// - Normal summary is tx or rx done; abnormal is fault, missing, card.
// - Writing one clears a status flag; each flag has an enable.
// - Summaries drop when enabled flags clear; events do not queue.
`define CDMA_DESC_BYTES 32'h00000010
`define CDMA_OFS_W0 2'h0
`define CDMA_BIT_OWN 31
`define CDMA_BIT_CES 30
`define CDMA_BIT_WRAP 5
`define CDMA_BIT_LINK 4
`define CDMA_BIT_FIRST 3
`define CDMA_BIT_FINAL 2
`define CDMA_BIT_SUPP 1
`define CDMA_BS2_HI 25
`define CDMA_BS2_LO 13
`define CDMA_BS1_HI 12
`define CDMA_BS1_LO 0
`define CDMA_HTRANS_IDLE 2'h0
`define CDMA_HTRANS_NONSEQ 2'h2
`define CDMA_HTRANS_SEQ 2'h3
`define CDMA_HBURST_SINGLE 3'h0
`define CDMA_HBURST_INCR 3'h1
`define CDMA_HBURST_INCR4 3'h3
`define CDMA_HBURST_INCR8 3'h5
`define CDMA_HBURST_INCR16 3'h7
`define CDMA_HSIZE_WORD 3'h2
`define CDMA_HRESP_OKAY 2'h0
`define CDMA_FIFO_DEPTH 32
`define CDMA_FIFO_AW 5
`define CDMA_FIFO_WIDTH 32
`define CDMA_ST_TX 0
`define CDMA_ST_RX 1
`define CDMA_ST_FBE 2
`define CDMA_ST_DU 3
`define CDMA_ST_CES 4
`define CDMA_STS_RESET 5'h00
`endif

// File: cdma_engine.v
`timescale 1ns/100ps
`include "cdma_defs.vh"

// ****************************************
// Data FIFO
// ****************************************
module cdma_fifo #(
  parameter W = `CDMA_FIFO_WIDTH,
  parameter D = `CDMA_FIFO_DEPTH,
  parameter AW = `CDMA_FIFO_AW
) (
  input wire sys_clk,
  input wire resetn,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  output wire [AW:0] level
);
  reg [W-1:0] mem_reg [0:D-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] cnt_reg;
  wire do_wr;
  wire do_rd;
  assign in_ready = (cnt_reg != D[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_ptr_reg];
  assign level = cnt_reg;
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;
  always @(posedge sys_clk) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_rd & ~do_wr) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ****************************************
// Descriptor DMA engine
// ****************************************
module cdma_engine (
  input wire sys_clk,
  input wire resetn,
  input wire start,
  input wire [31:0] list_base,
  input wire [4:0] skip_len,
  input wire fixed_burst_sel,
  input wire [2:0] burst_len_field,
  input wire to_card,
  input wire [6:0] card_err_flags,
  input wire card_rx_end,
  input wire [4:0] irq_en,
  input wire sts_clr_we,
  input wire [4:0] sts_clr_bits,
  output wire [4:0] status,
  output wire normal_sum,
  output wire abnormal_sum,
  output wire irq,
  output wire busy,
  output wire [31:0] haddr,
  output wire [1:0] htrans,
  output wire [2:0] hburst,
  output wire [2:0] hsize,
  output wire hwrite,
  output wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hready,
  input wire [1:0] hresp,
  output wire [31:0] card_tx_data,
  output wire card_tx_valid,
  input wire card_tx_ready,
  input wire [31:0] card_rx_data,
  input wire card_rx_valid,
  output wire card_rx_ready
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_FETCH = 7'h02;
  localparam [6:0] S_CHECK = 7'h04;
  localparam [6:0] S_DATA = 7'h08;
  localparam [6:0] S_CLOSE = 7'h10;
  localparam [6:0] S_STALL = 7'h20;
  localparam [6:0] S_HALT = 7'h40;

  // ****************************************
  // Burst helpers
  // ****************************************
  function [5:0] pbl_words;
    input [2:0] f;
    begin
      case (f)
        3'h0: pbl_words = 6'h01;
        3'h1: pbl_words = 6'h04;
        3'h2: pbl_words = 6'h08;
        3'h3: pbl_words = 6'h10;
        default: pbl_words = 6'h20;
      endcase
    end
  endfunction

  function [5:0] pick_len;
    input [10:0] r;
    input [5:0] p;
    input fx;
    reg [10:0] m;
    begin
      m = (r < {5'h00, p}) ? r : {5'h00, p};
      if (fx) begin
        if (m >= 11'h010) pick_len = 6'h10;
        else if (m >= 11'h008) pick_len = 6'h08;
        else if (m >= 11'h004) pick_len = 6'h04;
        else pick_len = 6'h01;
      end else begin
        pick_len = m[5:0];
      end
    end
  endfunction

  function [2:0] burst_code;
    input [5:0] l;
    input fx;
    begin
      if (l == 6'h01) burst_code = `CDMA_HBURST_SINGLE;
      else if (!fx) burst_code = `CDMA_HBURST_INCR;
      else if (l == 6'h10) burst_code = `CDMA_HBURST_INCR16;
      else if (l == 6'h08) burst_code = `CDMA_HBURST_INCR8;
      else burst_code = `CDMA_HBURST_INCR4;
    end
  endfunction

  reg [6:0] state_reg;
  reg [6:0] state_next;
  reg [4:0] sts_reg;
  reg [4:0] sts_next;
  reg [31:0] desc_reg [0:3];
  reg [31:0] cur_desc_reg;
  reg [31:0] buf_addr_reg;
  reg [10:0] rem_reg;
  reg buf2_reg;
  reg end_seen_reg;
  reg bus_busy_reg;
  reg [31:0] a_addr_reg;
  reg [5:0] len_reg;
  reg [5:0] a_cnt_reg;
  reg [5:0] d_cnt_reg;
  reg dph_reg;
  reg bwrite_reg;
  reg [2:0] burst_reg;
  reg [31:0] hwdata_reg;
  reg go;
  reg go_data;
  reg [31:0] go_addr;
  reg [5:0] go_len;
  reg go_wr;
  reg [2:0] go_burst;
  reg [4:0] ev;
  wire [31:0] w0;
  wire [31:0] w1;
  wire aph;
  wire bus_err;
  wire bus_end;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire [5:0] fifo_lvl;
  wire mem_push;
  wire mem_pop;
  wire [10:0] bs1_words;
  wire [10:0] bs2_words;
  wire more2;
  wire buf_done;
  wire [10:0] eff_rem;
  wire [5:0] dlen;
  wire room;
  wire [31:0] next_desc;
  wire [31:0] close_word;
  wire card_err;

  assign w0 = desc_reg[0];
  assign w1 = desc_reg[1];
  assign card_err = |card_err_flags;
  assign close_word = {1'b0, card_err, w0[29:0]};

  // ****************************************
  // Descriptor decode
  // ****************************************
  assign bs1_words = w1[`CDMA_BS1_HI:`CDMA_BS1_LO+2];
  assign bs2_words = w1[`CDMA_BS2_HI:`CDMA_BS2_LO+2];
  assign more2 = ~buf2_reg & ~w0[`CDMA_BIT_LINK] & (bs2_words != 11'h000);
  assign buf_done = (rem_reg == 11'h000) |
    (~to_card & end_seen_reg & w0[`CDMA_BIT_FINAL] &
     (fifo_lvl == 6'h00));
  assign eff_rem = (~to_card & end_seen_reg & w0[`CDMA_BIT_FINAL] &
    ({5'h00, fifo_lvl} < rem_reg)) ? {5'h00, fifo_lvl} : rem_reg;
  assign dlen = pick_len(eff_rem, pbl_words(burst_len_field), fixed_burst_sel);
  assign room = to_card ?
    ((6'd`CDMA_FIFO_DEPTH - fifo_lvl) >= dlen) : (fifo_lvl >= dlen);
  assign next_desc = w0[`CDMA_BIT_LINK] ? {desc_reg[3][31:2], 2'b00} :
    w0[`CDMA_BIT_WRAP] ? {list_base[31:2], 2'b00} :
    cur_desc_reg + `CDMA_DESC_BYTES + {25'h0, skip_len, 2'b00};

  // ****************************************
  // Master bus phases
  // ****************************************
  assign aph = bus_busy_reg & (a_cnt_reg != len_reg);
  assign bus_err = dph_reg & (hresp != `CDMA_HRESP_OKAY);
  assign bus_end = bus_busy_reg & hready & dph_reg & ~bus_err &
    (d_cnt_reg == len_reg - 6'h01);
  assign htrans = ~aph ? `CDMA_HTRANS_IDLE :
    (a_cnt_reg == 6'h00) ? `CDMA_HTRANS_NONSEQ : `CDMA_HTRANS_SEQ;
  assign haddr = a_addr_reg;
  assign hburst = burst_reg;
  assign hsize = `CDMA_HSIZE_WORD;
  assign hwrite = bwrite_reg;
  assign hwdata = hwdata_reg;
  assign mem_push = hready & dph_reg & ~bwrite_reg & (state_reg == S_DATA);
  assign mem_pop = hready & aph & bwrite_reg & (state_reg == S_DATA);

  // ****************************************
  // FIFO in the data path
  // ****************************************
  cdma_fifo #(
    .W(`CDMA_FIFO_WIDTH),
    .D(`CDMA_FIFO_DEPTH),
    .AW(`CDMA_FIFO_AW)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(to_card ? mem_push : card_rx_valid),
    .in_ready(fifo_in_ready),
    .in_data(to_card ? hrdata : card_rx_data),
    .out_valid(fifo_out_valid),
    .out_ready(to_card ? card_tx_ready : mem_pop),
    .out_data(fifo_out_data),
    .level(fifo_lvl)
  );
  assign card_tx_data = fifo_out_data;
  assign card_tx_valid = to_card & fifo_out_valid;
  assign card_rx_ready = ~to_card & fifo_in_ready;

  // ****************************************
  // Sequencing
  // ****************************************
  always @* begin
    state_next = state_reg;
    go = 1'b0;
    go_data = 1'b0;
    go_addr = 32'h00000000;
    go_len = 6'h04;
    go_wr = 1'b0;
    go_burst = `CDMA_HBURST_INCR4;
    ev = 5'h00;
    case (state_reg)
      S_IDLE: begin
        if (start) begin
          go = 1'b1;
          go_addr = {list_base[31:2], 2'b00};
          state_next = S_FETCH;
        end
      end
      S_FETCH: begin
        if (bus_end) state_next = S_CHECK;
      end
      S_CHECK: begin
        if (!w0[`CDMA_BIT_OWN]) begin
          ev[`CDMA_ST_DU] = 1'b1;
          state_next = S_STALL;
        end else begin
          state_next = S_DATA;
        end
      end
      S_DATA: begin
        if (!bus_busy_reg) begin
          if (buf_done) begin
            if (!more2) begin
              go = 1'b1;
              go_addr = cur_desc_reg + {30'h0, `CDMA_OFS_W0};
              go_len = 6'h01;
              go_wr = 1'b1;
              go_burst = `CDMA_HBURST_SINGLE;
              state_next = S_CLOSE;
            end
          end else if (room) begin
            go = 1'b1;
            go_data = 1'b1;
            go_addr = buf_addr_reg;
            go_len = dlen;
            go_wr = ~to_card;
            go_burst = burst_code(dlen, fixed_burst_sel);
          end
        end
      end
      S_CLOSE: begin
        if (bus_end) begin
          ev[`CDMA_ST_CES] = card_err;
          if (w0[`CDMA_BIT_FINAL]) begin
            if (!w0[`CDMA_BIT_SUPP]) begin
              ev[`CDMA_ST_TX] = to_card;
              ev[`CDMA_ST_RX] = ~to_card;
            end
            state_next = S_IDLE;
          end else begin
            go = 1'b1;
            go_addr = next_desc;
            state_next = S_FETCH;
          end
        end
      end
      S_STALL: begin
        if (start) begin
          go = 1'b1;
          go_addr = cur_desc_reg;
          state_next = S_FETCH;
        end
      end
      S_HALT: begin
        state_next = S_HALT;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    if (bus_err) begin
      go = 1'b0;
      ev[`CDMA_ST_FBE] = 1'b1;
      state_next = S_HALT;
    end
  end

  // ****************************************
  // Status flags and summaries
  // ****************************************
  always @* begin
    sts_next = sts_reg;
    if (sts_clr_we) begin
      sts_next = sts_next & ~sts_clr_bits;
    end
    sts_next = sts_next | ev;
  end
  assign status = sts_reg;
  assign normal_sum = |(sts_reg[`CDMA_ST_RX:`CDMA_ST_TX] &
    irq_en[`CDMA_ST_RX:`CDMA_ST_TX]);
  assign abnormal_sum = |(sts_reg[`CDMA_ST_CES:`CDMA_ST_FBE] &
    irq_en[`CDMA_ST_CES:`CDMA_ST_FBE]);
  assign irq = normal_sum | abnormal_sum;
  assign busy = (state_reg != S_IDLE);

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      sts_reg <= `CDMA_STS_RESET;
      desc_reg[0] <= 32'h00000000;
      desc_reg[1] <= 32'h00000000;
      desc_reg[2] <= 32'h00000000;
      desc_reg[3] <= 32'h00000000;
      cur_desc_reg <= 32'h00000000;
      buf_addr_reg <= 32'h00000000;
      rem_reg <= 11'h000;
      buf2_reg <= 1'b0;
      end_seen_reg <= 1'b0;
      bus_busy_reg <= 1'b0;
      a_addr_reg <= 32'h00000000;
      len_reg <= 6'h00;
      a_cnt_reg <= 6'h00;
      d_cnt_reg <= 6'h00;
      dph_reg <= 1'b0;
      bwrite_reg <= 1'b0;
      burst_reg <= `CDMA_HBURST_SINGLE;
      hwdata_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      sts_reg <= sts_next;
      if (go) begin
        bus_busy_reg <= 1'b1;
        a_addr_reg <= go_addr;
        len_reg <= go_len;
        a_cnt_reg <= 6'h00;
        d_cnt_reg <= 6'h00;
        bwrite_reg <= go_wr;
        burst_reg <= go_burst;
      end else begin
        if (hready & aph) begin
          a_addr_reg <= a_addr_reg + 32'h00000004;
          a_cnt_reg <= a_cnt_reg + 6'h01;
          if (bwrite_reg) begin
            hwdata_reg <= (state_reg == S_CLOSE) ? close_word : fifo_out_data;
          end
        end
        if (bus_err) begin
          bus_busy_reg <= 1'b0;
        end else if (hready & dph_reg) begin
          d_cnt_reg <= d_cnt_reg + 6'h01;
          if (~bwrite_reg & (state_reg == S_FETCH)) begin
            desc_reg[d_cnt_reg[1:0]] <= hrdata;
          end
          if (bus_end) bus_busy_reg <= 1'b0;
        end
      end
      if (bus_err) begin
        dph_reg <= 1'b0;
      end else if (hready) begin
        dph_reg <= aph;
      end
      if ((state_reg == S_IDLE) & start) begin
        cur_desc_reg <= {list_base[31:2], 2'b00};
        end_seen_reg <= 1'b0;
      end else if (card_rx_end) begin
        end_seen_reg <= 1'b1;
      end
      if ((state_reg == S_CHECK) & w0[`CDMA_BIT_OWN]) begin
        buf_addr_reg <= {desc_reg[2][31:2], 2'b00};
        rem_reg <= bs1_words;
        buf2_reg <= 1'b0;
      end
      if (go_data) begin
        buf_addr_reg <= buf_addr_reg + {24'h0, go_len, 2'b00};
        rem_reg <= rem_reg - {5'h00, go_len};
      end
      if ((state_reg == S_DATA) & ~bus_busy_reg & buf_done & more2) begin
        buf_addr_reg <= {desc_reg[3][31:2], 2'b00};
        rem_reg <= bs2_words;
        buf2_reg <= 1'b1;
      end
      if ((state_reg == S_CLOSE) & bus_end & ~w0[`CDMA_BIT_FINAL]) begin
        cur_desc_reg <= next_desc;
      end
    end
  end
endmodule

// File: cdma_engine_chk.sv
`timescale 1ns/100ps
`include "cdma_defs.vh"
// ********************
// Engine port checker
// ********************
module cdma_engine_chk (
  input wire sys_clk,
  input wire resetn,
  input wire start,
  input wire [31:0] list_base,
  input wire fixed_burst_sel,
  input wire [2:0] burst_len_field,
  input wire [4:0] irq_en,
  input wire sts_clr_we,
  input wire [4:0] sts_clr_bits,
  input wire [4:0] status,
  input wire normal_sum,
  input wire abnormal_sum,
  input wire irq,
  input wire busy,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire [2:0] hburst,
  input wire hready,
  input wire [1:0] hresp
);
  wire [4:0] keep_m = sts_clr_we ? ~sts_clr_bits : 5'h1f;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  a_norm_sum:
  assert property (normal_sum == |(status[1:0] & irq_en[1:0]))
    else $error("normal summary wrong");
  a_abn_sum:
  assert property (abnormal_sum == |(status[4:2] & irq_en[4:2]))
    else $error("abnormal summary wrong");
  a_irq_or:
  assert property (irq == (normal_sum | abnormal_sum))
    else $error("irq not summary or");
  a_start_fetch:
  assert property (start && !busy |=> htrans == `CDMA_HTRANS_NONSEQ &&
    hburst == `CDMA_HBURST_INCR4 && haddr == {$past(list_base[31:2]), 2'h0})
    else $error("start fetch wrong");
  a_addr_align:
  assert property (htrans[1] |-> haddr[1:0] == 2'h0)
    else $error("unaligned address");
  a_seq_step:
  assert property (htrans == `CDMA_HTRANS_SEQ && $past(htrans[1]) &&
    $past(hready) |-> haddr == $past(haddr) + 32'h4)
    else $error("burst step wrong");
  a_stall_hold:
  assert property (htrans[1] && !hready |=> htrans == $past(htrans) &&
    haddr == $past(haddr))
    else $error("request changed in wait");
  a_fault_idle:
  assert property (hready && hresp != `CDMA_HRESP_OKAY |=>
    htrans == `CDMA_HTRANS_IDLE && status[2])
    else $error("bus fault not taken");
  a_burst_kind:
  assert property (htrans == `CDMA_HTRANS_NONSEQ |-> (fixed_burst_sel ?
    hburst != `CDMA_HBURST_INCR : hburst < `CDMA_HBURST_INCR8) &&
    (burst_len_field != 3'h1 || hburst < `CDMA_HBURST_INCR8))
    else $error("burst kind wrong");
  a_clear_keep:
  assert property (1'b1 |=>
    ($past(status) & $past(keep_m) & ~status) == 5'h00)
    else $error("status bit lost");
endmodule

// File: cdma_mem.sv
`timescale 1ns/100ps
// ********************
// Bus memory model
// ********************
module cdma_mem (
  input wire sys_clk,
  input wire resetn,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire hready,
  output wire [1:0] hresp,
  input wire stall,
  input wire [31:0] err_addr
);
  reg [31:0] mem [0:511];
  reg on_reg, wr_reg, flip_reg;
  reg [31:0] at_reg;
  assign hready = ~stall;
  assign hresp = {1'b0, on_reg & ~stall & (at_reg == err_addr)};
  assign hrdata = (on_reg & ~wr_reg) ? mem[at_reg[10:2]] : {32{flip_reg}};
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      on_reg <= 1'b0;
      flip_reg <= 1'b0;
    end else begin
      flip_reg <= ~flip_reg;
      if (hready) begin
        if (on_reg & wr_reg)
          mem[at_reg[10:2]] <= hwdata;
        on_reg <= htrans[1];
        wr_reg <= hwrite;
        at_reg <= haddr;
      end
    end
  end
endmodule

// File: cdma_engine_tb.sv
`timescale 1ns/100ps
`include "cdma_defs.vh"
// ********************
// Engine bench
// ********************
module cdma_engine_tb;
  localparam [31:0] own_b = 32'h80000000, ces_b = 32'h40000000;
  localparam [31:0] wrap_b = 32'h20, link_b = 32'h10, first_b = 32'h8;
  localparam [31:0] final_b = 32'h4, supp_b = 32'h2;
  reg sys_clk = 1'b0, resetn = 1'b0, start = 1'b0, to_card = 1'b1;
  reg fixed_burst_sel = 1'b1, card_rx_end = 1'b0, sts_clr_we = 1'b0;
  reg card_tx_ready = 1'b0, card_rx_valid = 1'b0, stall = 1'b0;
  reg [31:0] list_base = 32'h100, card_rx_data = 32'h0, err_addr = 32'hff0;
  reg [4:0] skip_len = 5'h02, irq_en = 5'h1f, sts_clr_bits = 5'h00;
  reg [2:0] burst_len_field = 3'h1;
  reg [6:0] card_err_flags = 7'h00;
  wire [4:0] status;
  wire normal_sum, abnormal_sum, irq, busy, hwrite, hready;
  wire card_tx_valid, card_rx_ready;
  wire [31:0] haddr, hwdata, hrdata, card_tx_data;
  wire [1:0] htrans, hresp;
  wire [2:0] hburst, hsize;
  reg [31:0] tx_got [0:15];
  reg [31:0] rx_w [0:7];
  integer seed = 29080, fails = 0, checks_done = 0, j;
  integer tx_n = 0, tx_k = 0, want = 0, rx_i = 0, rx_n = 0;
  cdma_engine i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .start(start), .list_base(list_base),
    .skip_len(skip_len), .fixed_burst_sel(fixed_burst_sel),
    .burst_len_field(burst_len_field), .to_card(to_card),
    .card_err_flags(card_err_flags), .card_rx_end(card_rx_end),
    .irq_en(irq_en), .sts_clr_we(sts_clr_we), .sts_clr_bits(sts_clr_bits),
    .status(status), .normal_sum(normal_sum), .abnormal_sum(abnormal_sum),
    .irq(irq), .busy(busy), .haddr(haddr), .htrans(htrans), .hburst(hburst),
    .hsize(hsize), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
    .hready(hready), .hresp(hresp), .card_tx_data(card_tx_data),
    .card_tx_valid(card_tx_valid), .card_tx_ready(card_tx_ready),
    .card_rx_data(card_rx_data), .card_rx_valid(card_rx_valid),
    .card_rx_ready(card_rx_ready)
  );
  cdma_mem i_mem (
    .sys_clk(sys_clk), .resetn(resetn), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .hready(hready),
    .hresp(hresp), .stall(stall), .err_addr(err_addr)
  );
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (card_tx_valid && card_tx_ready) begin
      tx_got[tx_n[3:0]] <= card_tx_data;
      tx_n <= tx_n + 1;
    end
    if (card_rx_valid && card_rx_ready)
      rx_i <= rx_i + 1;
  end
  always @(negedge sys_clk) begin
    stall <= ($random(seed) & 3) == 0;
    card_tx_ready <= ^$random(seed);
    card_rx_valid <= !to_card && rx_i < rx_n;
    card_rx_data <= rx_w[rx_i[2:0]];
  end
  task close_out;
    begin
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    #500000;
    fails = fails + 1;
    close_out;
  end
  task chk(input [31:0] e, input [31:0] g, input [8*8:1] nm);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  function ready_f(input integer b);
    ready_f = b >= 0 ? status[b] === 1'b1 : b == -1 ? busy === 1'b0 :
      b == -2 ? tx_n >= want : rx_i >= rx_n;
  endfunction
  task wait_on(input integer b);
    integer n;
    begin
      n = 0;
      while (n < 3000 && !ready_f(b)) begin
        @(negedge sys_clk);
        n = n + 1;
      end
      chk(32'h0, n == 3000, "wait");
    end
  endtask
  task go;
    begin
      @(negedge sys_clk) start = 1'b1;
      @(negedge sys_clk) start = 1'b0;
    end
  endtask
  task clr(input [4:0] b);
    begin
      @(negedge sys_clk) sts_clr_we = 1'b1;
      sts_clr_bits = b;
      @(negedge sys_clk) sts_clr_we = 1'b0;
    end
  endtask
  function [31:0] sz(input [12:0] b2, input [12:0] b1);
    sz = {6'h00, b2, b1};
  endfunction
  task desc(input [31:0] a, input [31:0] w0, w1, w2, w3);
    begin
      i_mem.mem[a[10:2]] = w0;
      i_mem.mem[a[10:2] + 9'h1] = w1;
      i_mem.mem[a[10:2] + 9'h2] = w2;
      i_mem.mem[a[10:2] + 9'h3] = w3;
    end
  endtask
  task tx_cmp(input [31:0] a, input integer nw);
    integer i;
    begin
      for (i = 0; i < nw; i = i + 1) begin
        chk(i_mem.mem[a[10:2] + i], tx_got[tx_k], "tx data");
        tx_k = tx_k + 1;
      end
    end
  endtask
  initial begin
    for (j = 256; j < 512; j = j + 1)
      i_mem.mem[j] = $random(seed);
    repeat (3) @(negedge sys_clk);
    chk(32'h0, {busy, irq, htrans, status}, "reset");
    chk(`CDMA_HSIZE_WORD, hsize, "hsize");
    resetn = 1'b1;
    // ********************
    // Dual buffer ring
    // ********************
    desc(32'h100, own_b | first_b, sz(13'h0, 13'h00c), 32'h403, 0);
    desc(32'h118, own_b | wrap_b, sz(13'h4, 13'h8), 32'h480, 32'h4c1);
    desc(32'h130, own_b | final_b, sz(13'h0, 13'h4), 32'h4f0, 0);
    go;
    wait_on(3);
    chk(first_b, i_mem.mem[64], "word0 a");
    chk(wrap_b, i_mem.mem[70], "word0 b");
    chk(32'h1, abnormal_sum & irq, "abn sum");
    desc(32'h100, own_b | final_b, sz(13'h0, 13'h004), 32'h4e0, 0);
    clr(5'h08);
    go;
    wait_on(-1);
    want = 7;
    wait_on(-2);
    tx_cmp(32'h400, 3);
    tx_cmp(32'h480, 2);
    tx_cmp(32'h4c0, 1);
    tx_cmp(32'h4e0, 1);
    chk(7, tx_n, "tx count");
    chk(final_b, i_mem.mem[64], "word0 c");
    chk(5'h01, status, "sts tx");
    clr(5'h00);
    chk(5'h01, status, "sts keep");
    irq_en = 5'h1e;
    #1;
    chk(32'h0, normal_sum | irq, "masked");
    @(negedge sys_clk) irq_en = 5'h1f;
    clr(5'h01);
    chk(32'h0, {status, irq}, "cleared");
    $display("test ring done");
    // ********************
    // Chained receive
    // ********************
    to_card = 1'b0;
    fixed_burst_sel = 1'b0;
    burst_len_field = 3'h2;
    list_base = 32'h203;
    card_err_flags = 7'h04;
    desc(32'h200, own_b | link_b | first_b, 0, 0, 32'h243);
    desc(32'h240, own_b | final_b | supp_b, sz(13'h0, 13'h20), 32'h600, 0);
    for (j = 0; j < 4; j = j + 1)
      rx_w[j] = $random(seed);
    rx_n = 4;
    go;
    wait_on(-3);
    @(negedge sys_clk) card_rx_end = 1'b1;
    @(negedge sys_clk) card_rx_end = 1'b0;
    wait_on(-1);
    for (j = 0; j < 4; j = j + 1)
      chk(rx_w[j], i_mem.mem[384 + j], "rx data");
    chk(ces_b | final_b | supp_b, i_mem.mem[144], "word0 d");
    chk(5'h10, status, "sts rx");
    clr(5'h1f);
    $display("test chain done");
    // ********************
    // Bus fault
    // ********************
    to_card = 1'b1;
    fixed_burst_sel = 1'b1;
    burst_len_field = 3'h3;
    list_base = 32'h300;
    card_err_flags = 7'h00;
    err_addr = 32'h704;
    desc(32'h300, own_b | first_b | final_b, sz(13'h0, 13'h8), 32'h700, 0);
    go;
    wait_on(2);
    chk(32'h1, abnormal_sum, "fault");
    resetn = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(32'h0, {busy, status}, "reset 2");
    resetn = 1'b1;
    $display("test fault done");
    close_out;
  end
endmodule
bind cdma_engine cdma_engine_chk i_chk (
  .sys_clk(sys_clk), .resetn(resetn), .start(start), .list_base(list_base),
  .fixed_burst_sel(fixed_burst_sel), .burst_len_field(burst_len_field),
  .irq_en(irq_en), .sts_clr_we(sts_clr_we), .sts_clr_bits(sts_clr_bits),
  .status(status), .normal_sum(normal_sum), .abnormal_sum(abnormal_sum),
  .irq(irq), .busy(busy), .haddr(haddr), .htrans(htrans), .hburst(hburst),
  .hready(hready), .hresp(hresp)
);
